// File: include/adc_ctrl_pkg.sv
// Package with register map, field positions and timing counts for the converter control.
package adc_ctrl_pkg;
  localparam logic [7:0] ADDR_CONVERTER_CONTROL = 8'h1f;
  localparam logic [7:0] ADDR_CONVERSION_RESULT = 8'h1e;
  localparam logic [7:0] ADDR_PIN_ANALOG_CONFIG = 8'h20;
  localparam logic [7:0] ADDR_IRQ_STATUS = 8'h21;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'h22;
  localparam logic [7:0] CONTROL_RESET = 8'h00;
  localparam logic [7:0] CONTROL_WRITE_MASK = 8'hdd;
  localparam logic [2:0] PIN_CONFIG_RESET = 3'h0;
  localparam int CLK_SEL_HI = 7;
  localparam int CLK_SEL_LO = 6;
  localparam int CHAN_SEL_HI = 4;
  localparam int CHAN_SEL_LO = 3;
  localparam int START_DONE_BIT = 2;
  localparam int POWER_ON_BIT = 0;
  localparam int CFG_PCFG_HI = 1;
  localparam int CFG_PCFG_LO = 0;
  localparam int CFG_VREF_BIT = 2;
  localparam int IRQ_DONE_BIT = 0;
  localparam int IRQ_PINCHG_BIT = 1;
  localparam int IRQ_EXT_BIT = 2;
  localparam logic [4:0] DIV2_HALF = 5'h00;
  localparam logic [4:0] DIV8_HALF = 5'h03;
  localparam logic [4:0] DIV32_HALF = 5'h0f;
  localparam logic [2:0] SAR_LAST_BIT = 3'h0;
  localparam logic [3:0] INPUT_PINS_ANALOG = 4'hf;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_SAMPLE = 2'b01,
    ST_CONVERT = 2'b11,
    ST_FINISH = 2'b10
  } conv_state_type;
endpackage

// File: src/adc_clock_gen.sv
// Conversion clock tick generator: system clock divided, or internal RC tick.
`timescale 1ns/1ps
module adc_clock_gen (
  input wire logic i_clk,
  input wire logic i_srst,
  input wire logic i_run,
  input wire logic [1:0] i_select,
  input wire logic i_rc_tick,
  output logic o_tick
);
  typedef struct packed {
    logic [4:0] count;
    logic tick;
  } state_type;
  state_type state_reg;
  state_type state_next;
  logic [4:0] half;

  // Divider counts one half period; the RC code passes the free-running tick.
  always_comb begin
    state_next = state_reg;
    state_next.tick = 1'b0;
    case (i_select)
      2'b00: half = adc_ctrl_pkg::DIV2_HALF;
      2'b01: half = adc_ctrl_pkg::DIV8_HALF;
      2'b10: half = adc_ctrl_pkg::DIV32_HALF;
      default: half = adc_ctrl_pkg::DIV2_HALF;
    endcase
    if (!i_run) begin
      state_next.count = 5'h00;
    end else if (i_select == 2'b11) begin
      state_next.tick = i_rc_tick;
    end else if (state_reg.count >= half) begin
      state_next.count = 5'h00;
      state_next.tick = 1'b1;
    end else begin
      state_next.count = state_reg.count + 5'h01;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign o_tick = state_reg.tick;
endmodule // adc_clock_gen

// File: src/adc_conversion_control.sv
// Control, result and pin configuration logic of the four-input converter.
`timescale 1ns/1ps

// Overview of operation
// - Four inputs, 8-bit result per conversion.
// - Successive approximation, one bit per step.
// - Reference is supply or reference pin.
// - Conversions continue during sleep.
// - Result, operation control, pin configuration registers.
// - Pins set analog or digital, reference option.
// - Analog pins read zero; analog after reset.
// - Config write may set pin-change, external flags.
// - Clock select: divide 2, 8, 32, RC.
// - Channel select picks one of four inputs.
// - Writing start begins conversion; reads busy.
// - Start bit clears when conversion finishes.
// - Power bit enables; clear shuts converter off.
// - Operation control resets to zero.
module adc_conversion_control (
  input wire logic i_clk,
  input wire logic i_srst,
  input wire logic [7:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic i_comp_above,
  input wire logic i_rc_tick,
  input wire logic i_sleep,
  input wire logic [3:0] i_pin_digital,
  output logic [7:0] o_rdata,
  output logic [7:0] o_dac_code,
  output logic [1:0] o_channel,
  output logic o_sample,
  output logic o_vref_external,
  output logic o_analog_power,
  output logic [3:0] o_pin_analog,
  output logic [3:0] o_pin_read,
  output logic o_pin_change_flag,
  output logic o_external_irq_flag,
  output logic o_irq
);
  typedef struct packed {
    adc_ctrl_pkg::conv_state_type fsm;
    logic [7:0] control;
    logic [7:0] result;
    logic [2:0] pin_cfg;
    logic [2:0] irq_status;
    logic [2:0] irq_mask;
    logic [3:0] pin_view;
    logic [7:0] rdata;
    logic sample;
    logic irq;
    logic [3:0] pin_analog;
    logic vref_ext;
  } state_type;
  state_type state_reg;
  state_type state_next;

  logic conv_tick;
  logic sar_begin;
  logic [7:0] sar_trial;
  logic sar_last;
  logic running;
  logic [3:0] analog_mask;
  logic [3:0] new_view;
  logic [7:0] ctl_written;

  assign running = (state_reg.fsm != adc_ctrl_pkg::ST_IDLE);
  assign sar_begin = (state_reg.fsm == adc_ctrl_pkg::ST_SAMPLE) && conv_tick;

  // Conversion clock from the selected divider or the RC tick.
  adc_clock_gen u_clock_gen (
    .i_clk(i_clk),
    .i_srst(i_srst),
    .i_run(running),
    .i_select(state_reg.control[adc_ctrl_pkg::CLK_SEL_HI:adc_ctrl_pkg::CLK_SEL_LO]),
    .i_rc_tick(i_rc_tick),
    .o_tick(conv_tick)
  );

  // Bit-per-step approximation of the sampled input.
  adc_sar_step u_sar (
    .i_clk(i_clk),
    .i_srst(i_srst),
    .i_begin(sar_begin),
    .i_tick(conv_tick && (state_reg.fsm == adc_ctrl_pkg::ST_CONVERT)),
    .i_comp_above(i_comp_above),
    .o_trial(sar_trial),
    .o_last(sar_last)
  );

  // Pin configuration decode: code 0 all analog, 1 all analog with reference pin,
  // 2 only channel 0 analog, 3 all digital.
  always_comb begin
    case (state_reg.pin_cfg[adc_ctrl_pkg::CFG_PCFG_HI:adc_ctrl_pkg::CFG_PCFG_LO])
      2'b00: analog_mask = adc_ctrl_pkg::INPUT_PINS_ANALOG;
      2'b01: analog_mask = adc_ctrl_pkg::INPUT_PINS_ANALOG;
      2'b10: analog_mask = 4'h1;
      default: analog_mask = 4'h0;
    endcase
    new_view = i_pin_digital & ~analog_mask;
  end

  // Register writes, conversion sequence, flags and read data in one next-state block.
  always_comb begin
    state_next = state_reg;
    ctl_written = i_wdata & adc_ctrl_pkg::CONTROL_WRITE_MASK;
    state_next.pin_view = new_view;
    state_next.rdata = 8'h00;
    // Pin views and reference choice are registered so the outputs come from flip-flops.
    state_next.pin_analog = analog_mask;
    state_next.vref_ext = (state_reg.pin_cfg[1:0] == 2'b01) |
      state_reg.pin_cfg[adc_ctrl_pkg::CFG_VREF_BIT];
    if (i_wr) begin
      case (i_addr)
        adc_ctrl_pkg::ADDR_CONVERTER_CONTROL: begin
          // Start is only honoured while powered; software can clear it mid-conversion only by clearing power,
          // which also aborts the conversion, keeping the result and done flag coherent.
          state_next.control = ctl_written;
          state_next.control[adc_ctrl_pkg::START_DONE_BIT] =
            (ctl_written[adc_ctrl_pkg::START_DONE_BIT] &&
             ctl_written[adc_ctrl_pkg::POWER_ON_BIT]) || running;
          if (!ctl_written[adc_ctrl_pkg::POWER_ON_BIT]) begin
            state_next.control[adc_ctrl_pkg::START_DONE_BIT] = 1'b0;
          end
        end
        adc_ctrl_pkg::ADDR_PIN_ANALOG_CONFIG: state_next.pin_cfg = i_wdata[2:0];
        adc_ctrl_pkg::ADDR_IRQ_STATUS: state_next.irq_status = state_reg.irq_status &
          ~i_wdata[2:0];
        adc_ctrl_pkg::ADDR_IRQ_MASK: state_next.irq_mask = i_wdata[2:0];
        default: ;
      endcase
    end
    // A changed digital view raises the pin-change flag, and the external flag if pin 2 changed; placed after the clear so a set wins.
    if (new_view != state_reg.pin_view) begin
      state_next.irq_status[adc_ctrl_pkg::IRQ_PINCHG_BIT] = 1'b1;
      if (new_view[2] != state_reg.pin_view[2]) begin
        state_next.irq_status[adc_ctrl_pkg::IRQ_EXT_BIT] = 1'b1;
      end
    end
    // Sequencer; runs on the system clock regardless of sleep.
    case (state_reg.fsm)
      adc_ctrl_pkg::ST_IDLE: begin
        if (state_next.control[adc_ctrl_pkg::START_DONE_BIT]) begin
          state_next.fsm = adc_ctrl_pkg::ST_SAMPLE;
        end
      end
      adc_ctrl_pkg::ST_SAMPLE: begin
        if (conv_tick) begin
          state_next.fsm = adc_ctrl_pkg::ST_CONVERT;
        end
      end
      adc_ctrl_pkg::ST_CONVERT: begin
        if (conv_tick && sar_last) begin
          state_next.fsm = adc_ctrl_pkg::ST_FINISH;
        end
      end
      adc_ctrl_pkg::ST_FINISH: begin
        state_next.result = sar_trial;
        state_next.control[adc_ctrl_pkg::START_DONE_BIT] = 1'b0;
        state_next.irq_status[adc_ctrl_pkg::IRQ_DONE_BIT] = 1'b1;
        state_next.fsm = adc_ctrl_pkg::ST_IDLE;
      end
      default: state_next.fsm = adc_ctrl_pkg::ST_IDLE;
    endcase
    // Power removal aborts any conversion in flight.
    if (!state_next.control[adc_ctrl_pkg::POWER_ON_BIT]) begin
      state_next.fsm = adc_ctrl_pkg::ST_IDLE;
      state_next.control[adc_ctrl_pkg::START_DONE_BIT] = 1'b0;
    end
    state_next.sample = (state_next.fsm == adc_ctrl_pkg::ST_SAMPLE);
    if (i_rd) begin
      case (i_addr)
        adc_ctrl_pkg::ADDR_CONVERTER_CONTROL: state_next.rdata = state_reg.control;
        adc_ctrl_pkg::ADDR_CONVERSION_RESULT: state_next.rdata = state_reg.result;
        adc_ctrl_pkg::ADDR_PIN_ANALOG_CONFIG: state_next.rdata = {5'h00, state_reg.pin_cfg};
        adc_ctrl_pkg::ADDR_IRQ_STATUS: state_next.rdata = {5'h00, state_reg.irq_status};
        adc_ctrl_pkg::ADDR_IRQ_MASK: state_next.rdata = {5'h00, state_reg.irq_mask};
        default: state_next.rdata = 8'h00;
      endcase
    end
    state_next.irq = |(state_next.irq_status & state_next.irq_mask);
  end

  // All state registered together; reset leaves every pin analog and the converter off.
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      state_reg <= '0;
      state_reg.control <= adc_ctrl_pkg::CONTROL_RESET;
      state_reg.pin_cfg <= adc_ctrl_pkg::PIN_CONFIG_RESET;
      state_reg.pin_analog <= adc_ctrl_pkg::INPUT_PINS_ANALOG;
    end else begin
      state_reg <= state_next;
    end
  end

  // Sleep only gates nothing here; the input is kept for the integration.
  logic unused_sleep;
  assign unused_sleep = i_sleep;

  assign o_rdata = state_reg.rdata;
  assign o_dac_code = sar_trial;
  assign o_channel = state_reg.control[adc_ctrl_pkg::CHAN_SEL_HI:adc_ctrl_pkg::CHAN_SEL_LO];
  assign o_sample = state_reg.sample;
  assign o_vref_external = state_reg.vref_ext;
  assign o_analog_power = state_reg.control[adc_ctrl_pkg::POWER_ON_BIT];
  assign o_pin_analog = state_reg.pin_analog;
  assign o_pin_read = state_reg.pin_view;
  assign o_pin_change_flag = state_reg.irq_status[adc_ctrl_pkg::IRQ_PINCHG_BIT];
  assign o_external_irq_flag = state_reg.irq_status[adc_ctrl_pkg::IRQ_EXT_BIT];
  assign o_irq = state_reg.irq;
endmodule // adc_conversion_control

// File: src/adc_sar_step.sv
// Successive-approximation register: one result bit decided per tick.
`timescale 1ns/1ps
module adc_sar_step (
  input wire logic i_clk,
  input wire logic i_srst,
  input wire logic i_begin,
  input wire logic i_tick,
  input wire logic i_comp_above,
  output logic [7:0] o_trial,
  output logic o_last
);
  typedef struct packed {
    logic [7:0] trial;
    logic [2:0] bit_idx;
  } state_type;
  state_type state_reg;
  state_type state_next;

  // Keep or drop the bit under test from the comparator, then try the next one.
  always_comb begin
    state_next = state_reg;
    if (i_begin) begin
      state_next.trial = 8'h80;
      state_next.bit_idx = 3'h7;
    end else if (i_tick) begin
      if (i_comp_above) begin
        state_next.trial[state_reg.bit_idx] = 1'b0;
      end
      if (state_reg.bit_idx != adc_ctrl_pkg::SAR_LAST_BIT) begin
        state_next.bit_idx = state_reg.bit_idx - 3'h1;
        state_next.trial[state_reg.bit_idx - 3'h1] = 1'b1;
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign o_trial = state_reg.trial;
  assign o_last = (state_reg.bit_idx == adc_ctrl_pkg::SAR_LAST_BIT);
endmodule // adc_sar_step

// File: verification/adc_conversion_control_sva.sv
// Checker of the register port and conversion start behaviour of the converter control.
`timescale 1ns/1ps
module adc_conversion_control_sva (
  input wire logic i_clk,
  input wire logic i_srst,
  input wire logic [7:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic [7:0] o_rdata,
  input wire logic [1:0] o_channel,
  input wire logic o_sample,
  input wire logic o_analog_power
);
  localparam logic [7:0] CTL = adc_ctrl_pkg::ADDR_CONVERTER_CONTROL;
  logic mapped;
  // Decode of the five mapped places; anything else must read back zero.
  assign mapped = (i_addr >= adc_ctrl_pkg::ADDR_CONVERSION_RESULT) &&
    (i_addr <= adc_ctrl_pkg::ADDR_IRQ_MASK);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_srst);
  sequence s_ctl_write;
    i_wr && (i_addr == CTL);
  endsequence
  sequence s_ctl_read;
    i_rd && (i_addr == CTL);
  endsequence
  a_rdata_idle_zero: assert property (!i_rd |=> o_rdata == 8'h00)
    else $error("read data not zero outside a read answer");
  a_power_bit_follows: assert property (s_ctl_write |=> o_analog_power == $past(i_wdata[0]))
    else $error("power output does not follow written bit");
  a_channel_follows: assert property (s_ctl_write |=> o_channel == $past(i_wdata[4:3]))
    else $error("channel output does not follow written field");
  a_sample_needs_power: assert property (o_sample |-> o_analog_power)
    else $error("sampling while converter is off");
  a_start_when_off: assert property (s_ctl_write ##0 !i_wdata[0] ##1 !i_wr |-> !o_sample [*2])
    else $error("sampling with power bit clear");
  a_start_begins_sample: assert property (
    s_ctl_write ##0 (i_wdata[2] && i_wdata[0] && !o_analog_power) |=> ##1 o_sample)
    else $error("start did not begin sampling");
  a_reserved_read_zero: assert property (s_ctl_read |=> (o_rdata[5] == 1'b0) && (o_rdata[1] == 1'b0))
    else $error("reserved control bits read non-zero");
  a_unmapped_zero: assert property (i_rd && !mapped |=> o_rdata == 8'h00)
    else $error("unmapped address read non-zero");
endmodule // adc_conversion_control_sva

bind adc_conversion_control adc_conversion_control_sva u_sva (
  .i_clk(i_clk), .i_srst(i_srst), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
  .o_rdata(o_rdata), .o_channel(o_channel), .o_sample(o_sample), .o_analog_power(o_analog_power)
);

// File: verification/analog_source_model.sv
// Behavioural model of the analog inputs and the comparator that judges each trial code.
`timescale 1ns/1ps
module analog_source_model (
  input wire logic [1:0] i_channel,
  input wire logic [7:0] i_trial,
  input wire logic [31:0] i_levels,
  output logic o_comp_above
);
  logic [7:0] level;
  // The routed channel picks one of four input levels; a level under the trial drops the bit.
  assign level = i_levels[8*i_channel +: 8];
  assign o_comp_above = (level < i_trial);
endmodule // analog_source_model

// File: verification/testbench.sv
// Self-checking testbench of the converter control block.
`timescale 1ns/1ps
module testbench;
  localparam logic [7:0] CTL = adc_ctrl_pkg::ADDR_CONVERTER_CONTROL;
  localparam logic [7:0] RES = adc_ctrl_pkg::ADDR_CONVERSION_RESULT;
  localparam logic [7:0] PIN = adc_ctrl_pkg::ADDR_PIN_ANALOG_CONFIG;
  localparam logic [7:0] STA = adc_ctrl_pkg::ADDR_IRQ_STATUS;
  localparam logic [7:0] MSK = adc_ctrl_pkg::ADDR_IRQ_MASK;
  logic i_clk = 1'b0;
  logic i_srst, i_wr, i_rd, i_sleep, i_comp_above, o_vref_external, o_irq;
  logic o_pin_change_flag, o_external_irq_flag;
  logic i_rc_tick = 1'b0;
  logic [7:0] i_addr, i_wdata, o_rdata, o_dac_code, d;
  logic [1:0] o_channel;
  logic [3:0] i_pin_digital, o_pin_read, o_pin_analog;
  logic [31:0] levels;
  int seed = 32'h1ec66bb9;
  int error_cnt = 0;
  int n_checks = 0;
  always #20 i_clk = ~i_clk;
  // A steady internal RC tick; it runs slower than the divide-by-2 clock on purpose.
  always @(posedge i_clk) i_rc_tick <= ~i_rc_tick;
  adc_conversion_control DUT (.i_clk, .i_srst, .i_addr, .i_wdata, .i_wr, .i_rd, .i_comp_above,
    .i_rc_tick, .i_sleep, .i_pin_digital, .o_rdata, .o_dac_code, .o_channel, .o_sample(),
    .o_vref_external, .o_analog_power(), .o_pin_analog, .o_pin_read, .o_pin_change_flag,
    .o_external_irq_flag, .o_irq);
  analog_source_model u_src (.i_channel(o_channel), .i_trial(o_dac_code), .i_levels(levels),
    .o_comp_above(i_comp_above));
  // Successive approximation worked out bit by bit from the input level.
  function automatic logic [7:0] sar_exp(input logic [7:0] lvl);
    logic [7:0] t;
    t = 8'h00;
    for (int i = 7; i >= 0; i--) begin
      t[i] = 1'b1;
      if (lvl < t) t[i] = 1'b0;
    end
    return t;
  endfunction
  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
    n_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH at %0t: %0s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge i_clk);
    i_addr <= a; i_wdata <= v; i_wr <= 1'b1;
    @(posedge i_clk);
    i_wr <= 1'b0;
  endtask
  // Read data stand only in the cycle after the strobe, so they are taken just after that edge.
  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    @(posedge i_clk);
    i_addr <= a; i_rd <= 1'b1;
    @(posedge i_clk);
    i_rd <= 1'b0;
    #1 v = o_rdata;
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic conv(input logic [1:0] cs, input logic [1:0] ch);
    int i;
    wr(CTL, 8'h00);
    wr(CTL, {cs, 1'b0, ch, 3'b101});
    rd(CTL, d);
    chk(d, {cs, 1'b0, ch, 3'b101}, "control while busy");
    for (i = 0; i < 400; i++) begin
      rd(CTL, d);
      if (d[2] === 1'b0) break;
    end
    if (i == 400) begin
      error_cnt++;
      $display("MISMATCH at %0t: conversion never finished", $time);
      wrap_up();
    end else begin
      chk(d, {cs, 1'b0, ch, 3'b001}, "control after done");
      rd(RES, d);
      chk(d, sar_exp(levels[8*ch +: 8]), "result");
      chk({7'h00, o_irq}, 8'h01, "irq after done");
      wr(STA, 8'h01);
      repeat (2) @(posedge i_clk);
      #1 chk({7'h00, o_irq}, 8'h00, "irq after clear");
    end
  endtask
  initial begin
    logic [7:0] regs [6] = '{RES, CTL, PIN, STA, MSK, 8'h30};
    i_srst = 1'b1; i_addr = 8'h00; i_wdata = 8'h00; i_wr = 1'b0; i_rd = 1'b0;
    i_sleep = 1'b0; i_pin_digital = 4'h0; levels = 32'h0;
    repeat (10) @(posedge i_clk);
    i_srst <= 1'b0;
    foreach (regs[k]) begin
      rd(regs[k], d);
      chk(d, 8'h00, "reset value");
    end
    wr(CTL, 8'h22);
    rd(CTL, d);
    chk(d, 8'h00, "reserved bits");
    $display("test registers done");
    // Pin 2 is forced high so that the external flag is certain to be raised.
    i_pin_digital <= 4'($random(seed)) | 4'h4;
    wr(PIN, 8'h03);
    repeat (3) @(posedge i_clk);
    #1 chk({4'h0, o_pin_read}, {4'h0, i_pin_digital}, "digital pins");
    chk({4'h0, o_pin_analog}, 8'h00, "pins digital view");
    chk({6'h00, o_external_irq_flag, o_pin_change_flag},
      {6'h00, i_pin_digital[2], |i_pin_digital}, "pin flags");
    wr(PIN, 8'h01);
    repeat (3) @(posedge i_clk);
    #1 chk({4'h0, o_pin_read}, 8'h00, "analog pins");
    chk({4'h0, o_pin_analog}, 8'h0f, "pins analog view");
    chk({7'h00, o_vref_external}, 8'h01, "reference pin");
    wr(PIN, 8'h00);
    wr(STA, 8'h07);
    wr(MSK, 8'h01);
    $display("test pins done");
    // Corner levels first, then random ones; every clock code and channel is visited.
    for (int n = 0; n < 12; n++) begin
      levels <= (n == 0) ? 32'h0 : (n == 1) ? 32'hffffffff : $random(seed);
      i_sleep <= n[0];
      conv((n < 4) ? n[1:0] : 2'($random(seed)), (n < 4) ? n[1:0] : 2'($random(seed)));
    end
    $display("test conversions done");
    wrap_up();
  end
endmodule // testbench
